// ### src/ccp_pkg.sv
// Shared constants, mode codes and helpers for the capture/compare unit
package ccp_pkg;

   // ==========================================================
   // Register map
   // ==========================================================
   localparam int          ADDR_W          = 3;
   localparam logic [2:0]  OFF_CONTROL     = 3'h0;
   localparam logic [2:0]  OFF_VALUE_LOW   = 3'h1;
   localparam logic [2:0]  OFF_VALUE_HIGH  = 3'h2;
   localparam logic [2:0]  OFF_STATUS      = 3'h3;

   // ==========================================================
   // Field layout and reset values
   // ==========================================================
   localparam int          CTRL_W          = 6;
   localparam int          MODE_LSB        = 0;
   localparam int          MODE_MSB        = 3;
   localparam int          DUTY_LSB        = 4;
   localparam int          DUTY_MSB        = 5;
   localparam int          STAT_FLAG_BIT   = 0;
   localparam logic [5:0]  CTRL_RESET      = 6'h00;
   localparam logic [15:0] VALUE_RESET     = 16'h0000;
   localparam logic [7:0]  RDATA_IDLE      = 8'h00;

   // ==========================================================
   // Mode codes
   // ==========================================================
   localparam logic [3:0]  MODE_OFF        = 4'h0;
   localparam logic [3:0]  MODE_CAP_FALL   = 4'h4;
   localparam logic [3:0]  MODE_CAP_RISE   = 4'h5;
   localparam logic [3:0]  MODE_CAP_RISE4  = 4'h6;
   localparam logic [3:0]  MODE_CAP_RISE16 = 4'h7;
   localparam logic [3:0]  MODE_CMP_SET    = 4'h8;
   localparam logic [3:0]  MODE_CMP_CLR    = 4'h9;
   localparam logic [3:0]  MODE_CMP_SOFT   = 4'ha;
   localparam logic [3:0]  MODE_CMP_SPEC   = 4'hb;

   // Prescaler terminal counts
   localparam logic [1:0]  PS4_LAST        = 2'h3;
   localparam logic [3:0]  PS16_LAST       = 4'hf;

   // Special event trigger states
   typedef enum logic [1:0] {
      TRG_IDLE  = 2'b01,
      TRG_ARMED = 2'b10
   } ccp_trg_t;

   // ==========================================================
   // Mode decoding helpers
   // ==========================================================
   function automatic logic ccp_is_capture(input logic [3:0] mode);
      return mode[3:2] == 2'b01;
   endfunction : ccp_is_capture

   function automatic logic ccp_is_compare(input logic [3:0] mode);
      return mode[3:2] == 2'b10;
   endfunction : ccp_is_compare

   function automatic logic ccp_is_pwm(input logic [3:0] mode);
      return mode[3:2] == 2'b11;
   endfunction : ccp_is_pwm

endpackage : ccp_pkg

// ### src/ccp_edge_prescale.sv
// Pin synchroniser, edge detector and capture prescaler
module ccp_edge_prescale (
   input  wire logic       clk_sys,      // System clock
   input  wire logic       rst_n,        // Async reset, active low
   input  wire logic       pin_level,    // Pad level of the unit pin
   input  wire logic [3:0] mode,         // Current mode select field
   output logic            capture       // One-cycle capture event
);

   typedef struct packed {
      logic       s1;
      logic       s2;
      logic       s3;
      logic [3:0] cnt;
      logic       capture;
   } ccp_eps_t;

   ccp_eps_t st;
   ccp_eps_t next_st;
   logic     rise;
   logic     fall;

   // ==========================================================
   // Edge detect and prescale
   // ==========================================================
   // Edges come from the second and third stages only
   assign rise = st.s2 & ~st.s3;
   assign fall = ~st.s2 & st.s3;

   // Pad level is watched whatever the pin direction is
   always_comb begin
      next_st    = st;
      next_st.s1 = pin_level;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      // Counter free-runs on rising edges, so a prescale change
      // keeps it; the price is an early or late first capture
      if (!ccp_pkg::ccp_is_capture(mode)) begin
         next_st.cnt = 4'h0;
      end else if (rise) begin
         next_st.cnt = st.cnt + 4'h1;
      end
      case (mode)
         ccp_pkg::MODE_CAP_FALL:   next_st.capture = fall;
         ccp_pkg::MODE_CAP_RISE:   next_st.capture = rise;
         ccp_pkg::MODE_CAP_RISE4:  next_st.capture =
            rise && (st.cnt[1:0] == ccp_pkg::PS4_LAST);
         ccp_pkg::MODE_CAP_RISE16: next_st.capture =
            rise && (st.cnt == ccp_pkg::PS16_LAST);
         default:                  next_st.capture = 1'b0;
      endcase
   end

   // State register
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign capture = st.capture;

   // ==========================================================
   // Checks
   // ==========================================================
   a_presc_cleared: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      !ccp_pkg::ccp_is_capture(mode) |=> st.cnt == 4'h0)
      else $error("prescaler not cleared outside capture");

   a_presc_kept: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ccp_pkg::ccp_is_capture(mode) && !rise |=> $stable(st.cnt))
      else $error("prescaler moved without an edge");

   a_fall_capture: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      mode == ccp_pkg::MODE_CAP_FALL && $fell(st.s2) |=> capture)
      else $error("falling edge missed");

   a_single_capture: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      capture |=> !capture)
      else $error("capture longer than one cycle");

endmodule : ccp_edge_prescale

// ### src/ccp_unit.sv
// Capture/compare unit top: registers, capture, compare and trigger
// Function
// - Mode 0000 turns unit off and resets it
// - Codes 0001-0011 reserved, no function
// - Capture edge chosen by mode 0100-0111
// - Capture copies 16-bit timer count
// - Every capture sets sticky event flag
// - New capture overwrites value, no lockout
// - Edge detector watches pad even when driving
// - Prescaler cleared when off, non-capture, reset
// - Prescale change keeps counter; spurious flag possible
// - Compare tests value against timer continuously
// - Modes 1000/1001 drive pin high/low, flag
// - Mode 1010 only flags, pin untouched
// - Mode 1011 flags, resets timer, starts conversion
// - Modes 110x/111x PWM high/low, bit0 ignored
// - Control bits 5:4 duty LSBs, PWM only
// - Control bits 7:6 read as zero
// - Writing zero forces compare latch low
// - Trigger immediate; timer reset on next tick
//
// Our own choices: the address-and-strobe port and the placing of the registers.
module ccp_unit (
   input  wire logic        clk_sys,          // System clock, 25 MHz
   input  wire logic        rst_n,            // Async reset, active low
   input  wire logic [2:0]  reg_addr,         // Register address
   input  wire logic [7:0]  reg_wdata,        // Register write data
   input  wire logic        reg_wr,           // Write strobe
   input  wire logic        reg_rd,           // Read strobe
   output logic      [7:0]  reg_rdata,        // Read data, cycle after
   input  wire logic [15:0] timer_one_count,  // Timer1 count pair
   input  wire logic        timer_one_tick,   // Timer1 rising clock edge
   input  wire logic        adc_enable,       // Converter is enabled
   input  wire logic        unit_pin_in,      // Pad level of unit pin
   output logic             unit_pin_out,     // Compare output latch
   output logic             unit_pin_oe_n,    // Low while unit drives pin
   output logic             unit_event_flag,  // Sticky event flag
   output logic             timer_one_reset,  // Timer1 reset pulse
   output logic             adc_start,        // Conversion start pulse
   output logic             pwm_enable,       // PWM mode selected
   output logic             pwm_active_low,   // PWM output polarity low
   output logic      [1:0]  duty_low_bits     // Duty LSBs in PWM mode
);

   // ==========================================================
   // State
   // ==========================================================
   typedef struct packed {
      logic [5:0]       ctrl;
      logic [15:0]      value;
      logic             flag;
      logic [7:0]       rdata;
      logic             cmp_latch;
      logic             pin_oe_n;
      logic             match_q;
      ccp_pkg::ccp_trg_t trg;
      logic             tmr_reset;
      logic             adc_start;
      logic             pwm_en;
      logic             pwm_low;
      logic [1:0]       duty;
   } ccp_state_t;

   ccp_state_t st;
   ccp_state_t next_st;

   logic [3:0] mode;
   logic       cap_pulse;
   logic       do_capture;
   logic       match;
   logic       match_rise;
   logic       wr_ctrl;
   logic       wr_low;
   logic       wr_high;
   logic       wr_stat;

   assign mode = st.ctrl[ccp_pkg::MODE_MSB:ccp_pkg::MODE_LSB];

   // ==========================================================
   // Edge detector and prescaler
   // ==========================================================
   ccp_edge_prescale u_edge (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .pin_level (unit_pin_in),
      .mode      (mode),
      .capture   (cap_pulse)
   );

   // ==========================================================
   // Decode
   // ==========================================================
   // Write strobes per register
   assign wr_ctrl = reg_wr && (reg_addr == ccp_pkg::OFF_CONTROL);
   assign wr_low  = reg_wr && (reg_addr == ccp_pkg::OFF_VALUE_LOW);
   assign wr_high = reg_wr && (reg_addr == ccp_pkg::OFF_VALUE_HIGH);
   assign wr_stat = reg_wr && (reg_addr == ccp_pkg::OFF_STATUS);

   // Capture pulse is a cycle old, so gate it with the live mode
   assign do_capture = cap_pulse && ccp_pkg::ccp_is_capture(mode);

   // Equality is tested every cycle; only its rising edge acts,
   // so a long match gives one event, not one per cycle
   assign match = ccp_pkg::ccp_is_compare(mode)
                  && (st.value == timer_one_count);
   assign match_rise = match && !st.match_q;

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb begin
      next_st           = st;
      next_st.tmr_reset = 1'b0;
      next_st.adc_start = 1'b0;
      next_st.rdata     = ccp_pkg::RDATA_IDLE;
      next_st.match_q   = match;

      // Control register, two top bits not stored
      if (wr_ctrl) begin
         next_st.ctrl = reg_wdata[5:0];
      end

      // Value pair, capture wins over a software write
      if (wr_low) begin
         next_st.value[7:0] = reg_wdata;
      end
      if (wr_high) begin
         next_st.value[15:8] = reg_wdata;
      end
      if (do_capture) begin
         next_st.value = timer_one_count;
      end

      // Sticky flag: write one clears, a new event wins
      if (wr_stat && reg_wdata[ccp_pkg::STAT_FLAG_BIT]) begin
         next_st.flag = 1'b0;
      end
      if (do_capture || match_rise) begin
         next_st.flag = 1'b1;
      end

      // Compare output latch
      if (match_rise && mode == ccp_pkg::MODE_CMP_SET) begin
         next_st.cmp_latch = 1'b1;
      end
      if (match_rise && mode == ccp_pkg::MODE_CMP_CLR) begin
         next_st.cmp_latch = 1'b0;
      end
      if (wr_ctrl && reg_wdata == 8'h00) begin
         next_st.cmp_latch = 1'b0;
      end

      // Pin is driven only in set and clear compare modes
      next_st.pin_oe_n = !(mode == ccp_pkg::MODE_CMP_SET
                           || mode == ccp_pkg::MODE_CMP_CLR);

      // Special event: conversion at once, timer reset on tick
      case (st.trg)
         ccp_pkg::TRG_IDLE: begin
            if (match_rise && mode == ccp_pkg::MODE_CMP_SPEC) begin
               next_st.trg       = ccp_pkg::TRG_ARMED;
               next_st.adc_start = adc_enable;
            end
         end
         ccp_pkg::TRG_ARMED: begin
            // Moving the value off the match cancels the reset
            if (!match || mode != ccp_pkg::MODE_CMP_SPEC) begin
               next_st.trg = ccp_pkg::TRG_IDLE;
            end else if (timer_one_tick) begin
               next_st.trg       = ccp_pkg::TRG_IDLE;
               next_st.tmr_reset = 1'b1;
            end
         end
         default: begin
            next_st.trg = ccp_pkg::TRG_IDLE;
         end
      endcase

      // PWM decode; bit 0 of the mode does not matter
      next_st.pwm_en  = ccp_pkg::ccp_is_pwm(mode);
      next_st.pwm_low = ccp_pkg::ccp_is_pwm(mode) && mode[1];
      next_st.duty    = ccp_pkg::ccp_is_pwm(mode)
                        ? st.ctrl[ccp_pkg::DUTY_MSB:ccp_pkg::DUTY_LSB]
                        : 2'h0;

      // Off: compare latch, trigger and match history back to reset; reserved codes idle
      if (mode == ccp_pkg::MODE_OFF) begin
         next_st.cmp_latch = 1'b0;
         next_st.trg       = ccp_pkg::TRG_IDLE;
         next_st.match_q   = 1'b0;
      end

      // Read port, data one cycle after the strobe
      if (reg_rd) begin
         case (reg_addr)
            ccp_pkg::OFF_CONTROL:    next_st.rdata =
               {2'b00, st.ctrl};
            ccp_pkg::OFF_VALUE_LOW:  next_st.rdata = st.value[7:0];
            ccp_pkg::OFF_VALUE_HIGH: next_st.rdata = st.value[15:8];
            ccp_pkg::OFF_STATUS:     next_st.rdata =
               {7'h00, st.flag};
            default:                 next_st.rdata =
               ccp_pkg::RDATA_IDLE;
         endcase
      end
   end

   // ==========================================================
   // State register
   // ==========================================================
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st.ctrl      <= ccp_pkg::CTRL_RESET;
         st.value     <= ccp_pkg::VALUE_RESET;
         st.flag      <= 1'b0;
         st.rdata     <= ccp_pkg::RDATA_IDLE;
         st.cmp_latch <= 1'b0;
         st.pin_oe_n  <= 1'b1;
         st.match_q   <= 1'b0;
         st.trg       <= ccp_pkg::TRG_IDLE;
         st.tmr_reset <= 1'b0;
         st.adc_start <= 1'b0;
         st.pwm_en    <= 1'b0;
         st.pwm_low   <= 1'b0;
         st.duty      <= 2'h0;
      end else begin
         st <= next_st;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign reg_rdata       = st.rdata;
   assign unit_pin_out    = st.cmp_latch;
   assign unit_pin_oe_n   = st.pin_oe_n;
   assign unit_event_flag = st.flag;
   assign timer_one_reset = st.tmr_reset;
   assign adc_start       = st.adc_start;
   assign pwm_enable      = st.pwm_en;
   assign pwm_active_low  = st.pwm_low;
   assign duty_low_bits   = st.duty;

   // ==========================================================
   // Checks
   // ==========================================================
   a_off_resets: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      mode == ccp_pkg::MODE_OFF |=>
         !unit_pin_out && st.trg == ccp_pkg::TRG_IDLE)
      else $error("unit not reset while off");

   a_reserved_idle: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      mode inside {4'h1, 4'h2, 4'h3} && $stable(mode) && !wr_ctrl
         |=> !match && !do_capture && unit_pin_oe_n)
      else $error("reserved code acts");

   a_capture_value: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      do_capture |=> st.value == $past(timer_one_count))
      else $error("capture did not load timer count");

   a_capture_flag: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      do_capture |=> unit_event_flag)
      else $error("capture did not set flag");

   a_flag_sticky: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      unit_event_flag && !(wr_stat && reg_wdata[0]) |=> unit_event_flag)
      else $error("flag dropped without software clear");

   a_compare_set: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      match_rise && mode == ccp_pkg::MODE_CMP_SET && !wr_ctrl
         |=> unit_pin_out && unit_event_flag)
      else $error("set on match failed");

   a_compare_clr: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      match_rise && mode == ccp_pkg::MODE_CMP_CLR
         |=> !unit_pin_out && unit_event_flag)
      else $error("clear on match failed");

   a_soft_no_pin: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      mode == ccp_pkg::MODE_CMP_SOFT |=> unit_pin_oe_n)
      else $error("pin driven in flag-only mode");

   a_special_adc: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      match_rise && mode == ccp_pkg::MODE_CMP_SPEC
         && st.trg == ccp_pkg::TRG_IDLE
         |=> adc_start == $past(adc_enable))
      else $error("conversion start not immediate");

   a_reset_on_tick: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      timer_one_reset |-> $past(timer_one_tick) && $past(match))
      else $error("timer reset without tick and match");

   a_zero_write: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      wr_ctrl && reg_wdata == 8'h00 |=> !unit_pin_out [*2])
      else $error("compare latch not forced low");

   a_ctrl_top_zero: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      reg_rd && reg_addr == ccp_pkg::OFF_CONTROL
         |=> reg_rdata[7:6] == 2'b00)
      else $error("control top bits not zero");

   a_duty_pwm_only: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      !pwm_enable |-> duty_low_bits == 2'h0)
      else $error("duty bits out of PWM");

   a_soft_flag: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      match_rise && mode == ccp_pkg::MODE_CMP_SOFT |=> unit_event_flag)
      else $error("flag-only match did not set flag");

   a_special_flag: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      match_rise && mode == ccp_pkg::MODE_CMP_SPEC
         |=> unit_event_flag && unit_pin_oe_n)
      else $error("special trigger flag or pin wrong");

   a_pwm_low_mode: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      mode[3:1] == 3'b111 |=> pwm_enable && pwm_active_low)
      else $error("active-low PWM mode not decoded");

   a_trigger_cancel: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      st.trg == ccp_pkg::TRG_ARMED && !match |=> !timer_one_reset)
      else $error("timer reset after match was lost");

endmodule : ccp_unit

// ### sim/ccp_pin_partner.sv
// Pin model: external event source, pull-down and unit drive
module ccp_pin_partner (
   input  wire logic unit_pin_out,   // Unit compare output latch
   input  wire logic unit_pin_oe_n,  // Low while unit drives pin
   input  wire logic src_en,         // Event source drives the pin
   input  wire logic src_lv,         // Level from the event source
   output logic      pin_level       // Resolved pad level
);
   timeunit 1ns;
   timeprecision 1ns;

   // ======================================
   // Wire resolution
   // ======================================
   // Pull-down wins when nobody drives, so no stale level is shown
   always_comb begin
      pin_level = 1'b0;
      if (src_en) begin
         pin_level = src_lv;
      end
      if (!unit_pin_oe_n) begin
         pin_level = unit_pin_out;
      end
   end
endmodule : ccp_pin_partner

// ### sim/tb_top.sv
// Self-checking testbench for the capture/compare unit
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [2:0] A_CTL = ccp_pkg::OFF_CONTROL;
   localparam logic [2:0] A_LO  = ccp_pkg::OFF_VALUE_LOW;
   localparam logic [2:0] A_HI  = ccp_pkg::OFF_VALUE_HIGH;
   localparam logic [2:0] A_ST  = ccp_pkg::OFF_STATUS;
   logic        clk_sys   = 1'b0;
   logic        rst_n     = 1'b0;
   logic [2:0]  reg_addr  = 3'h0;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr    = 1'b0;
   logic        reg_rd    = 1'b0;
   logic [15:0] tcount    = 16'h0000;
   logic        tick      = 1'b0;
   logic        adc_en    = 1'b0;
   logic        src_en    = 1'b1;
   logic        src_lv    = 1'b0;
   logic [7:0]  rdata;
   logic [1:0]  duty;
   logic        pin, p_out, oe_n, flag, t_rst, adc_go, pwm_en, pwm_lo;
   int          n_fail      = 0;
   int          checks_done = 0;

   ccp_unit dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(rdata), .timer_one_count(tcount),
      .timer_one_tick(tick), .adc_enable(adc_en), .unit_pin_in(pin),
      .unit_pin_out(p_out), .unit_pin_oe_n(oe_n),
      .unit_event_flag(flag), .timer_one_reset(t_rst),
      .adc_start(adc_go), .pwm_enable(pwm_en),
      .pwm_active_low(pwm_lo), .duty_low_bits(duty)
   );
   ccp_pin_partner partner (
      .unit_pin_out(p_out), .unit_pin_oe_n(oe_n), .src_en(src_en),
      .src_lv(src_lv), .pin_level(pin)
   );

   // System clock, 40 ns period
   always #20 clk_sys = ~clk_sys;

   // ======================================
   // Compare and access tasks
   // ======================================
   task automatic chkb(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chkb
   task automatic chk1(input string nm, input logic e, input logic g);
      chkb(nm, {7'h00, e}, {7'h00, g});
   endtask : chk1
   // Extra edge lets outputs that follow the mode settle
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      @(posedge clk_sys);
      #1;
   endtask : wr
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      chkb("reg_rdata", e, rdata);
   endtask : rd
   task automatic clr;
      wr(A_ST, 8'h01);
   endtask : clr
   // Pin change, then enough edges for sync and capture
   task automatic pin_to(input logic lv);
      @(posedge clk_sys);
      src_lv <= lv;
      repeat (6) @(posedge clk_sys);
      #1;
   endtask : pin_to
   task automatic pulses(input int n);
      repeat (n) begin
         pin_to(1'b0);
         pin_to(1'b1);
      end
   endtask : pulses
   // Timer moves only on a clock edge, as a synchronous counter would
   task automatic hit(input logic [15:0] v);
      @(posedge clk_sys);
      tcount <= v;
      @(posedge clk_sys);
      #1;
   endtask : hit
   task automatic ps(input logic [7:0] code, input int n);
      wr(A_CTL, 8'h00);
      wr(A_CTL, code);
      clr();
      pulses(n - 1);
      chk1("flag", 1'b0, flag);
      pulses(1);
      chk1("flag", 1'b1, flag);
   endtask : ps
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_sim

   // Watchdog cuts a hung run short
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_fail++;
      end_sim();
   end

   // ======================================
   // Main sequence
   // ======================================
   initial begin
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(A_CTL, 8'h00);
      rd(A_HI, 8'h00);
      rd(A_ST, 8'h00);
      chk1("oe_n", 1'b1, oe_n);
      wr(3'h6, 8'h3f);
      rd(3'h6, 8'h00);
      rd(A_CTL, 8'h00);
      wr(A_CTL, 8'hff);
      rd(A_CTL, 8'h3f);
      chk1("pwm_lo", 1'b1, pwm_lo);
      chkb("duty", 8'h03, {6'h00, duty});
      wr(A_CTL, 8'h2c);
      chk1("pwm_en", 1'b1, pwm_en);
      chk1("pwm_lo", 1'b0, pwm_lo);
      chkb("duty", 8'h02, {6'h00, duty});
      wr(A_CTL, 8'h35);
      chkb("duty", 8'h00, {6'h00, duty});
      wr(A_CTL, 8'h03);
      clr();
      pulses(2);
      chk1("flag", 1'b0, flag);
      chk1("oe_n", 1'b1, oe_n);
      $display("register test done");
      wr(A_CTL, 8'h05);
      clr();
      pin_to(1'b0);
      chk1("flag", 1'b0, flag);
      hit(16'h1234);
      pin_to(1'b1);
      chk1("flag", 1'b1, flag);
      pin_to(1'b0);
      hit(16'hbeef);
      pin_to(1'b1);
      rd(A_LO, 8'hef);
      rd(A_HI, 8'hbe);
      chk1("flag", 1'b1, flag);
      wr(A_CTL, 8'h04);
      clr();
      hit(16'h0a0b);
      pin_to(1'b0);
      rd(A_LO, 8'h0b);
      $display("capture test done");
      wr(A_CTL, 8'h00);
      wr(A_CTL, 8'h06);
      clr();
      pulses(2);
      wr(A_CTL, 8'h07);
      clr();
      pulses(13);
      chk1("flag", 1'b0, flag);
      pulses(1);
      chk1("flag", 1'b1, flag);
      ps(8'h06, 4);
      ps(8'h07, 16);
      $display("prescaler test done");
      @(posedge clk_sys);
      src_en <= 1'b0;
      wr(A_LO, 8'h10);
      wr(A_HI, 8'h20);
      hit(16'h0000);
      wr(A_CTL, 8'h08);
      clr();
      chk1("oe_n", 1'b0, oe_n);
      hit(16'h2010);
      chk1("flag", 1'b1, flag);
      chk1("pin", 1'b1, pin);
      clr();
      chk1("flag", 1'b0, flag);
      wr(A_CTL, 8'h09);
      hit(16'h0000);
      hit(16'h2010);
      chk1("pin_out", 1'b0, p_out);
      wr(A_CTL, 8'h08);
      hit(16'h0000);
      hit(16'h2010);
      wr(A_CTL, 8'h00);
      chk1("pin_out", 1'b0, p_out);
      chk1("oe_n", 1'b1, oe_n);
      wr(A_CTL, 8'h0a);
      clr();
      hit(16'h0000);
      hit(16'h2010);
      chk1("flag", 1'b1, flag);
      chk1("oe_n", 1'b1, oe_n);
      wr(A_CTL, 8'h0b);
      clr();
      @(posedge clk_sys);
      adc_en <= 1'b1;
      hit(16'h0000);
      hit(16'h2010);
      chk1("adc_start", 1'b1, adc_go);
      chk1("t_rst", 1'b0, t_rst);
      chk1("flag", 1'b1, flag);
      @(posedge clk_sys);
      tick <= 1'b1;
      #1;
      chk1("adc_start", 1'b0, adc_go);
      @(posedge clk_sys);
      tick <= 1'b0;
      #1;
      chk1("t_rst", 1'b1, t_rst);
      @(posedge clk_sys);
      adc_en <= 1'b0;
      hit(16'h0000);
      hit(16'h2010);
      chk1("adc_start", 1'b0, adc_go);
      hit(16'h0000);
      @(posedge clk_sys);
      tick <= 1'b1;
      @(posedge clk_sys);
      tick <= 1'b0;
      #1;
      chk1("t_rst", 1'b0, t_rst);
      $display("compare test done");
      end_sim();
   end
endmodule : tb_top
